// *** sts_params.svh ***
// register indices, reset values and timing constants of the standby scan block
`ifndef STS_PARAMS_SVH
`define STS_PARAMS_SVH

// register indices; byte address is four times the index
`define STS_IDX_NOISE   10'h038
`define STS_IDX_CHEN    10'h040
`define STS_IDX_CFG     10'h041
`define STS_IDX_GAIN    10'h042
`define STS_IDX_LEVEL   10'h043
`define STS_IDX_CTRL    10'h044
`define STS_IDX_STATUS  10'h045
`define STS_IDX_MASK    10'h046
`define STS_IDX_TOUCH   10'h047

// reset values
`define STS_RST_NOISE   8'h01
`define STS_RST_CHEN    8'h00
`define STS_RST_CFG     8'h39
`define STS_RST_GAIN    8'h02
`define STS_RST_LEVEL   8'h40
`define STS_RST_CTRL    8'h00
`define STS_RST_STATUS  7'h00
`define STS_RST_MASK    7'h00

// timing: clock rate and the unit steps of sample and cycle time
`define STS_CLK_MHZ      40
`define STS_SAMP_UNIT_US 320
`define STS_CYC_UNIT_US  35000

// threshold fractions, in eighths of the standby level
`define STS_EIGHTHS_SHIFT 3
`define STS_NOISE_E0      4'h2
`define STS_NOISE_E1      4'h3
`define STS_NOISE_E2      4'h4
`define STS_NOISE_E3      4'h5
`define STS_MTP_E0        4'h1
`define STS_MTP_E1        4'h2
`define STS_MTP_E2        4'h3
`define STS_MTP_E3        4'h8

// saturation ceiling of the reported delta
`define STS_DELTA_MAX     7'h7F
// status bit of the stretched-cycle event
`define STS_STRETCH_BIT   6

`endif

// *** sts_pkg.sv ***
// types shared by the standby touch scan block
`default_nettype none
package sts_pkg;

  typedef struct packed {
    logic [5:0] rsvd;
    logic [1:0] noise_threshold_pct;
  } sts_noise_reg_type;

  typedef struct packed {
    logic [1:0] rsvd;
    logic       standby_chan6_enable;
    logic       standby_chan5_enable;
    logic       standby_chan4_enable;
    logic       standby_chan3_enable;
    logic       standby_chan2_enable;
    logic       standby_chan1_enable;
  } sts_chen_reg_type;

  typedef struct packed {
    logic       accumulate_not_average;
    logic [2:0] standby_sample_count;
    logic [1:0] standby_sample_time;
    logic [1:0] standby_cycle_time;
  } sts_cfg_reg_type;

  typedef struct packed {
    logic [4:0] rsvd;
    logic [2:0] standby_sensitivity;
  } sts_gain_reg_type;

  typedef struct packed {
    logic       rsvd;
    logic [6:0] level;
  } sts_level_reg_type;

  typedef struct packed {
    logic [4:0] rsvd;
    logic [1:0] mtp_pct;
    logic       digital_noise_disable;
  } sts_ctrl_reg_type;

  typedef struct packed {
    logic [5:0] touch;
    logic [5:0] noise;
    logic [5:0] mtp_over;
  } sts_result_type;

  typedef enum logic [1:0] {
    ST_OFF    = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_EVAL   = 2'b10,
    ST_IDLE   = 2'b11
  } sts_state_type;

endpackage
`default_nettype wire

// *** sts_standby_scan.sv ***
// standby scan sequencer, delta evaluation and apb register file
//
// Function
// - delta above noise level but not above touch level flags a noise spike
// - digital noise disable bit suppresses the noise spike flag
// - noise level is 25, 37.5, 50 or 62.5 percent of touch level
// - six enable bits pick standby channels; all off after reset
// - enabled channels use standby level, averaging and sensitivity
// - accumulate bit selects sum instead of average of the samples
// - sample count field sets burst length; burst runs on one channel
// - sample time field gives 320us, 640us, 1.28ms or 2.56ms
// - cycle time field gives 35, 70, 105 or 140 ms
// - channels sampled at cycle start, low power idle for the remainder
// - cycle stretches when sampling outlasts the programmed period
// - sensitivity field picks multiplier 128x down by halves to 1x
// - delta msb weighs 64 raw counts at 128x, 8192 at 1x
// - standby level register resets to 40h; delta above it is touch
// - pattern detection level is a fraction of the standby level
//
// The APB register port was chosen for this implementation.
`include "sts_params.svh"
`default_nettype none

module sts_standby_scan
  import sts_pkg::*;
#(
  parameter int RAW_W         = 16,
  parameter int SAMP_UNIT_CYC = `STS_SAMP_UNIT_US * `STS_CLK_MHZ,
  parameter int CYC_UNIT_CYC  = `STS_CYC_UNIT_US * `STS_CLK_MHZ
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // apb slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // analog front end
  input  wire logic             standby_mode,
  input  wire logic [RAW_W-1:0] raw_count,
  output logic                  sense_enable,
  output logic      [2:0]       sense_chan,
  output logic                  low_power_idle,
  // results
  output sts_result_type        scan_result,
  output logic                  irq
);

  localparam int SAMP_W = 24;
  localparam int CYC_W  = 26;
  localparam int ACC_W  = RAW_W + 8;

  // ---------------------------------------------------------------- functions
  // sample time decode
  function automatic logic [SAMP_W-1:0] samp_len(input logic [1:0] f);
    samp_len = SAMP_W'(SAMP_UNIT_CYC) << f;
  endfunction

  function automatic logic [CYC_W-1:0] cyc_len(input logic [1:0] f);
    logic [CYC_W-1:0] u;
    u = CYC_W'(CYC_UNIT_CYC);
    case (f)
      2'h0:    cyc_len = u;
      2'h1:    cyc_len = u << 1;
      2'h2:    cyc_len = (u << 1) + u;
      2'h3:    cyc_len = u << 2;
      default: cyc_len = u;
    endcase
  endfunction

  // level times eighths, truncated
  function automatic logic [6:0] frac_of(input logic [6:0] lvl, input logic [3:0] e);
    logic [10:0] p;
    p = 11'(lvl) * 11'(e);
    frac_of = p[6+`STS_EIGHTHS_SHIFT:`STS_EIGHTHS_SHIFT];
  endfunction

  // lowest enabled channel at or above start; msb flags a hit
  function automatic logic [3:0] next_chan(input logic [5:0] en, input logic [2:0] start);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 5; i >= 0; i--) begin
      if (en[i] && (3'(i) >= start)) begin
        r = {1'b1, 3'(i)};
      end
    end
    next_chan = r;
  endfunction

  // ---------------------------------------------------------------- registers
  sts_noise_reg_type noise_q;
  sts_chen_reg_type  chen_q;
  sts_cfg_reg_type   cfg_q;
  sts_gain_reg_type  gain_q;
  sts_level_reg_type level_q;
  sts_ctrl_reg_type  ctrl_q;
  logic [6:0]        status_q;
  logic [6:0]        mask_q;
  logic [31:0]       prdata_q;

  // scan state
  sts_state_type     state_q;
  sts_cfg_reg_type   act_cfg_q;
  sts_gain_reg_type  act_gain_q;
  logic [2:0]        chan_q;
  logic [SAMP_W-1:0] samp_cnt_q;
  logic [7:0]        nsamp_q;
  logic [ACC_W-1:0]  acc_q;
  logic [CYC_W-1:0]  cyc_cnt_q;
  sts_result_type    res_q;

  // ---------------------------------------------------------------- apb decode
  logic [9:0]  idx;
  logic        mapped;
  logic        setup_ph;
  logic        wr_en;
  logic [31:0] rd_val;
  logic [6:0]  status_set;

  assign idx      = paddr[11:2];
  assign setup_ph = psel && !penable;
  assign wr_en    = psel && penable && pwrite && mapped;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped;
  assign prdata   = prdata_q;

  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h0000_0000;
    case (idx)
      `STS_IDX_NOISE:  rd_val = {24'h00_0000, noise_q};
      `STS_IDX_CHEN:   rd_val = {24'h00_0000, chen_q};
      `STS_IDX_CFG:    rd_val = {24'h00_0000, cfg_q};
      `STS_IDX_GAIN:   rd_val = {24'h00_0000, gain_q};
      `STS_IDX_LEVEL:  rd_val = {24'h00_0000, level_q};
      `STS_IDX_CTRL:   rd_val = {24'h00_0000, ctrl_q};
      `STS_IDX_STATUS: rd_val = {25'h000_0000, status_q};
      `STS_IDX_MASK:   rd_val = {25'h000_0000, mask_q};
      `STS_IDX_TOUCH:  rd_val = {26'h000_0000, res_q.touch};
      default:         mapped = 1'b0;
    endcase
  end

  // read data captured in setup so it stands through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_ph) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rd_val;
    end
  end

  // reserved bits are forced to zero on write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      noise_q <= `STS_RST_NOISE;
      chen_q  <= `STS_RST_CHEN;
      cfg_q   <= `STS_RST_CFG;
      gain_q  <= `STS_RST_GAIN;
      level_q <= `STS_RST_LEVEL;
      ctrl_q  <= `STS_RST_CTRL;
      mask_q  <= `STS_RST_MASK;
    end else if (wr_en) begin
      case (idx)
        `STS_IDX_NOISE: noise_q <= {6'h00, pwdata[1:0]};
        `STS_IDX_CHEN:  chen_q  <= {2'h0, pwdata[5:0]};
        `STS_IDX_CFG:   cfg_q   <= pwdata[7:0];
        `STS_IDX_GAIN:  gain_q  <= {5'h00, pwdata[2:0]};
        `STS_IDX_LEVEL: level_q <= {1'b0, pwdata[6:0]};
        `STS_IDX_CTRL:  ctrl_q  <= {5'h00, pwdata[2:0]};
        `STS_IDX_MASK:  mask_q  <= pwdata[6:0];
        default:        ;
      endcase
    end
  end

  // sticky status, write one to clear; a new event outranks the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= `STS_RST_STATUS;
    end else begin
      status_q <= (status_q & ~((wr_en && idx == `STS_IDX_STATUS) ? pwdata[6:0] : 7'h00))
                  | status_set;
    end
  end

  assign irq = |(status_q & mask_q);

  // ---------------------------------------------------------------- evaluation
  logic [5:0]       en_vec;
  logic [3:0]       first_hit;
  logic [3:0]       next_hit;
  logic             start_ok;
  logic             samp_done;
  logic             burst_done;
  logic [7:0]       nsamp_last;
  logic [ACC_W-1:0] acc_sum;
  logic [ACC_W-1:0] combined;
  logic [ACC_W-1:0] scaled;
  logic [6:0]       delta;
  logic [6:0]       noise_lvl;
  logic [6:0]       mtp_lvl;
  logic [3:0]       noise_e;
  logic [3:0]       mtp_e;
  logic             is_touch;
  logic             is_noise;
  logic             is_mtp;
  logic             cyc_over;

  // only enabled channels enter the scan
  assign en_vec     = chen_q[5:0];
  assign first_hit  = next_chan(en_vec, 3'h0);
  assign next_hit   = next_chan(en_vec, chan_q + 3'h1);
  assign start_ok   = standby_mode && first_hit[3];
  assign samp_done  = samp_cnt_q == samp_len(act_cfg_q.standby_sample_time) - SAMP_W'(1);
  // burst length is a power of two, 8 after reset
  assign nsamp_last = 8'(8'h01 << act_cfg_q.standby_sample_count) - 8'h01;
  assign burst_done = samp_done && (nsamp_q == nsamp_last);
  assign acc_sum    = acc_q + ACC_W'(raw_count);
  assign cyc_over   = cyc_cnt_q >= cyc_len(act_cfg_q.standby_cycle_time) - CYC_W'(1);

  // sum or average of the burst
  assign combined = act_cfg_q.accumulate_not_average ? acc_q
                                                     : acc_q >> act_cfg_q.standby_sample_count;
  // raw counts per lsb double with each sensitivity step
  assign scaled   = combined >> act_gain_q.standby_sensitivity;
  // saturation keeps a summed touch from wrapping around
  assign delta    = (|scaled[ACC_W-1:7]) ? `STS_DELTA_MAX : scaled[6:0];

  always_comb begin
    case (noise_q.noise_threshold_pct)
      2'h0:    noise_e = `STS_NOISE_E0;
      2'h1:    noise_e = `STS_NOISE_E1;
      2'h2:    noise_e = `STS_NOISE_E2;
      2'h3:    noise_e = `STS_NOISE_E3;
      default: noise_e = `STS_NOISE_E1;
    endcase
    case (ctrl_q.mtp_pct)
      2'h0:    mtp_e = `STS_MTP_E0;
      2'h1:    mtp_e = `STS_MTP_E1;
      2'h2:    mtp_e = `STS_MTP_E2;
      2'h3:    mtp_e = `STS_MTP_E3;
      default: mtp_e = `STS_MTP_E0;
    endcase
  end

  // noise level as a fraction of the standby level
  assign noise_lvl = frac_of(level_q.level, noise_e);
  // pattern level from the standby level, not the active ones
  assign mtp_lvl   = frac_of(level_q.level, mtp_e);
  assign is_touch  = delta > level_q.level;
  // noise spike window, disabled by the control bit
  assign is_noise  = !ctrl_q.digital_noise_disable && (delta > noise_lvl) && !is_touch;
  assign is_mtp    = delta > mtp_lvl;

  // ---------------------------------------------------------------- sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_OFF;
    end else begin
      case (state_q)
        ST_OFF: begin
          if (start_ok) begin
            state_q <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          if (!standby_mode) begin
            state_q <= ST_OFF;
          end else if (burst_done) begin
            state_q <= ST_EVAL;
          end
        end
        ST_EVAL: begin
          if (!standby_mode) begin
            state_q <= ST_OFF;
          end else if (next_hit[3]) begin
            state_q <= ST_SAMPLE;
          end else begin
            // rest of the period spent idle
            state_q <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (!standby_mode) begin
            state_q <= ST_OFF;
          end else if (cyc_over) begin
            state_q <= start_ok ? ST_SAMPLE : ST_OFF;
          end
        end
        default: state_q <= ST_OFF;
      endcase
    end
  end

  logic cyc_start;
  assign cyc_start = start_ok && ((state_q == ST_OFF) || (state_q == ST_IDLE && cyc_over));

  // working copy of timing and sensitivity taken only at cycle start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_cfg_q  <= `STS_RST_CFG;
      act_gain_q <= `STS_RST_GAIN;
    end else if (cyc_start) begin
      act_cfg_q  <= cfg_q;
      act_gain_q <= gain_q;
    end
  end

  // period counter saturates, so an overrun cycle ends at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_cnt_q <= '0;
    end else if (cyc_start || state_q == ST_OFF) begin
      cyc_cnt_q <= '0;
    end else if (!(&cyc_cnt_q)) begin
      cyc_cnt_q <= cyc_cnt_q + CYC_W'(1);
    end
  end

  // whole burst on one channel before stepping to the next
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_q <= 3'h0;
    end else if (cyc_start) begin
      chan_q <= first_hit[2:0];
    end else if (state_q == ST_EVAL && next_hit[3]) begin
      chan_q <= next_hit[2:0];
    end
  end

  // one sample per sample window, raw count taken at its last edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      samp_cnt_q <= '0;
      nsamp_q    <= 8'h00;
      acc_q      <= '0;
    end else if (state_q == ST_SAMPLE) begin
      if (samp_done) begin
        samp_cnt_q <= '0;
        nsamp_q    <= nsamp_q + 8'h01;
        acc_q      <= burst_done ? acc_q : acc_sum;
      end else begin
        samp_cnt_q <= samp_cnt_q + SAMP_W'(1);
      end
      if (burst_done) begin
        acc_q <= acc_sum;
      end
    end else if (state_q != ST_EVAL) begin
      samp_cnt_q <= '0;
      nsamp_q    <= 8'h00;
      acc_q      <= '0;
    end else begin
      // combined result was consumed in eval; clear for the next burst
      samp_cnt_q <= '0;
      nsamp_q    <= 8'h00;
      acc_q      <= '0;
    end
  end

  // per-channel results, disabled channels cleared when the running cycle ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_q <= '0;
    end else if (state_q == ST_OFF || !standby_mode) begin
      res_q <= '0;
    end else if (state_q == ST_EVAL) begin
      res_q.touch[chan_q]    <= is_touch;
      res_q.noise[chan_q]    <= is_noise;
      res_q.mtp_over[chan_q] <= is_mtp;
    end else if (cyc_start) begin
      res_q.touch    <= res_q.touch & en_vec;
      res_q.noise    <= res_q.noise & en_vec;
      res_q.mtp_over <= res_q.mtp_over & en_vec;
    end
  end

  // events: new touch per channel, and a cycle that overran its period
  always_comb begin
    status_set = 7'h00;
    if (state_q == ST_EVAL && is_touch && !res_q.touch[chan_q]) begin
      status_set[chan_q] = 1'b1;
    end
    // sampling outlasted the period; the idle phase lasts a single clock
    if (state_q == ST_EVAL && !next_hit[3] && cyc_over) begin
      status_set[`STS_STRETCH_BIT] = 1'b1;
    end
  end

  assign sense_enable   = state_q == ST_SAMPLE;
  assign sense_chan     = chan_q;
  // low power only in the idle state, not in off or eval
  assign low_power_idle = state_q == ST_IDLE;
  assign scan_result    = res_q;

endmodule
`default_nettype wire

// *** sts_scan_properties.sv ***
// port-level assertions for the standby scan block
`default_nettype none
module sts_scan_properties
  import sts_pkg::*;
#(
  parameter int RAW_W         = 16,
  parameter int SAMP_UNIT_CYC = 4,
  parameter int CYC_UNIT_CYC  = 200
) (
  // clock and reset
  input wire logic             pclk,
  input wire logic             presetn,
  // apb
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [11:0]      paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  // front end and results
  input wire logic             standby_mode,
  input wire logic [RAW_W-1:0] raw_count,
  input wire logic             sense_enable,
  input wire logic [2:0]       sense_chan,
  input wire logic             low_power_idle,
  input wire sts_result_type   scan_result,
  input wire logic             irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  zero_wait_a: assert property (pready)
    else $error("pready low");
  err_in_access_a: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  unmapped_zero_a: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("unmapped read data not zero");
  upper_zero_a: assert property (prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  touch_not_noise_a:
    assert property ((scan_result.touch & scan_result.noise) == 6'h00)
    else $error("touch and noise flagged together");
  off_quiet_a:
    assert property (!standby_mode |=> !sense_enable && !low_power_idle)
    else $error("activity while standby off");
  off_clears_a:
    assert property (!standby_mode |=> scan_result == '0)
    else $error("results kept while standby off");
  burst_one_chan_a:
    assert property (sense_enable && $past(sense_enable) |-> $stable(sense_chan))
    else $error("channel changed inside a burst");
  eval_then_idle_a:
    assert property ($rose(low_power_idle) |-> !$past(sense_enable) && !sense_enable)
    else $error("idle entered straight from sampling");
  sample_min_len_a:
    assert property ($rose(sense_enable) |=> (sense_enable || !$past(standby_mode))[*3])
    else $error("sample window shorter than four cycles");
  sense_idle_excl_a:
    assert property (!(sense_enable && low_power_idle))
    else $error("sampling and idle together");
endmodule
`default_nettype wire

// *** sts_pad_model.sv ***
// behavioural sensor pads answering the scan sequencer with per-channel counts
`default_nettype none
module sts_pad_model #(
  parameter int RAW_W = 16
) (
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // scan side
  input  wire logic               sense_enable,
  input  wire logic [2:0]         sense_chan,
  output logic      [RAW_W-1:0]   raw_count,
  // bench control
  input  wire logic [6*RAW_W-1:0] pad_level
);
  logic [RAW_W-1:0] last_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      last_q <= '0;
    else
      last_q <= raw_count;
  end
  // with sensing off, the output toggles each clock between the last count and its complement
  assign raw_count = sense_enable ? pad_level[sense_chan*RAW_W +: RAW_W] : ~last_q;
endmodule
`default_nettype wire

// *** sts_standby_scan_tb.sv ***
// self-checking bench for the standby scan block
`include "sts_params.svh"
`default_nettype none
module sts_standby_scan_tb
  import sts_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SU = 4;
  localparam int CU = 200;
  logic           pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic           standby_mode, sense_enable, low_power_idle, irq;
  logic [11:0]    paddr;
  logic [31:0]    pwdata, prdata, rdat;
  logic [15:0]    raw_count;
  logic [2:0]     sense_chan;
  logic [95:0]    pad_level;
  logic           rerr;
  sts_result_type scan_result, er;
  int             failures, tests_run, hi, per, idl;

  sts_standby_scan #(.RAW_W(16), .SAMP_UNIT_CYC(SU), .CYC_UNIT_CYC(CU)) u_sts_standby_scan (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .standby_mode(standby_mode), .raw_count(raw_count), .sense_enable(sense_enable),
    .sense_chan(sense_chan), .low_power_idle(low_power_idle), .scan_result(scan_result),
    .irq(irq));
  sts_pad_model #(.RAW_W(16)) u_sts_pad_model (
    .pclk(pclk), .presetn(presetn), .sense_enable(sense_enable), .sense_chan(sense_chan),
    .raw_count(raw_count), .pad_level(pad_level));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  function automatic logic [6:0] dlt(input logic [15:0] r, input logic [2:0] n,
                                     input logic sm, input logic [2:0] sn);
    logic [23:0] s;
    s = 24'(r) << n;
    if (!sm)
      s = s >> n;
    s = s >> sn;
    return (s > 24'h7F) ? 7'h7F : s[6:0];
  endfunction

  function automatic sts_result_type ev(input logic [95:0] v, input logic [5:0] ch,
      input logic [7:0] cf, input logic [2:0] sn, input logic [1:0] np, input logic dis,
      input int mt);
    sts_result_type r;
    logic [6:0]     d;
    r = '0;
    for (int i = 0; i < 6; i++) begin
      if (ch[i]) begin
        d = dlt(v[i*16 +: 16], cf[6:4], cf[7], sn);
        r.touch[i] = d > 7'h40;
        r.noise[i] = !dis && !r.touch[i] && (int'(d) * 8 > 64 * (int'(np) + 2));
        r.mtp_over[i] = int'(d) * 8 > 64 * mt;
      end
    end
    return r;
  endfunction

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [9:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(nm, {24'h0, exp}, rdat);
  endtask

  task automatic scan_chk(input string nm, input sts_result_type exp);
    repeat (2 * CU) @(posedge pclk);
    @(negedge pclk);
    chk(nm, 32'(exp), 32'(scan_result));
  endtask

  task automatic irq_chk(input logic exp);
    @(negedge pclk);
    chk("irq", {31'h0, exp}, {31'h0, irq});
  endtask

  // one burst length and one full period, from a fresh cycle start
  task automatic meas();
    hi = 0;
    per = 0;
    idl = 0;
    @(negedge pclk);
    while (sense_enable !== 1'b0) @(negedge pclk);
    while (sense_enable !== 1'b1) @(negedge pclk);
    while (sense_enable === 1'b1) begin
      hi++;
      @(negedge pclk);
    end
    per = hi;
    while (sense_enable !== 1'b1) begin
      per++;
      if (low_power_idle === 1'b1) idl++;
      @(negedge pclk);
    end
  endtask

  task automatic t_reset();
    rdchk("noise_rst", `STS_IDX_NOISE, 8'h01);
    rdchk("chen_rst", `STS_IDX_CHEN, 8'h00);
    rdchk("cfg_rst", `STS_IDX_CFG, 8'h39);
    rdchk("gain_rst", `STS_IDX_GAIN, 8'h02);
    rdchk("level_rst", `STS_IDX_LEVEL, 8'h40);
    apb(1'b1, `STS_IDX_CHEN, 8'hFF);
    rdchk("chen_rsvd", `STS_IDX_CHEN, 8'h3F);
    apb(1'b0, 10'h0FF, 8'h00);
    chk("unmapped_err", 32'h1, {31'h0, rerr});
    chk("unmapped_data", 32'h0, rdat);
  endtask

  task automatic t_noise();
    pad_level <= {16'h0011, 16'h0019, 16'h0021, 16'h0029, 16'h0040, 16'h0041};
    apb(1'b1, `STS_IDX_CFG, 8'h00);
    apb(1'b1, `STS_IDX_GAIN, 8'h00);
    standby_mode <= 1'b1;
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, `STS_IDX_NOISE, 8'(p));
      // pattern fraction stepped too: 1, 2, 3, 8 eighths
      apb(1'b1, `STS_IDX_CTRL, 8'(2 * p));
      er = ev(pad_level, 6'h3F, 8'h00, 3'h0, 2'(p), 1'b0, (p == 3) ? 8 : p + 1);
      scan_chk("noise_scan", er);
    end
    apb(1'b1, `STS_IDX_CTRL, 8'h01);
    scan_chk("noise_off", ev(pad_level, 6'h3F, 8'h00, 3'h0, 2'h3, 1'b1, 1));
    rdchk("touch_reg", `STS_IDX_TOUCH, 8'h01);
  endtask

  task automatic t_irq();
    rdchk("status_touch", `STS_IDX_STATUS, 8'h01);
    irq_chk(1'b0);
    apb(1'b1, `STS_IDX_MASK, 8'h01);
    irq_chk(1'b1);
    apb(1'b1, `STS_IDX_STATUS, 8'h7F);
    irq_chk(1'b0);
    rdchk("status_clr", `STS_IDX_STATUS, 8'h00);
  endtask

  task automatic t_off();
    standby_mode <= 1'b0;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk("off_result", 32'h0, 32'(scan_result));
    chk("off_sense", 32'h0, {31'h0, sense_enable});
    chk("off_idle", 32'h0, {31'h0, low_power_idle});
  endtask

  // summation kept to small counts, as for proximity use
  task automatic t_sens();
    apb(1'b1, `STS_IDX_CTRL, 8'h00);
    apb(1'b1, `STS_IDX_CHEN, 8'h03);
    standby_mode <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      for (int s = 0; s < 8; s++) begin
        pad_level <= {64'h0, 16'(16 << s), 16'(17 << s)};
        apb(1'b1, `STS_IDX_GAIN, 8'(s));
        apb(1'b1, `STS_IDX_CFG, {1'(m), 7'h20});
        er = ev(pad_level, 6'h03, {1'(m), 7'h20}, 3'(s), 2'h3, 1'b0, 1);
        scan_chk("gain_scan", er);
      end
    end
  endtask

  task automatic t_time();
    pad_level <= '0;
    apb(1'b1, `STS_IDX_CHEN, 8'h01);
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, `STS_IDX_CFG, {1'b0, 3'(c), 2'(c), 2'(c)});
      meas();
      chk("burst_len", 32'((SU << c) << c), 32'(hi));
      chk("cycle_len", 32'(CU * (c + 1)), 32'(per));
      chk("idle_len", 32'(CU * (c + 1) - ((SU << c) << c) - 1), 32'(idl));
    end
  endtask

  task automatic t_over();
    apb(1'b1, `STS_IDX_STATUS, 8'h7F);
    apb(1'b1, `STS_IDX_MASK, 8'h40);
    apb(1'b1, `STS_IDX_CFG, 8'h70);
    meas();
    chk("stretch_burst", 32'h200, 32'(hi));
    chk("stretch_cycle", 32'h202, 32'(per));
    chk("stretch_idle", 32'h1, 32'(idl));
    irq_chk(1'b1);
    rdchk("status_over", `STS_IDX_STATUS, 8'h40);
  endtask

  task automatic wrap_up();
    if (failures == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge pclk);
    failures++;
    wrap_up();
  end

  initial begin
    failures = 0;
    tests_run = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    standby_mode = 1'b0;
    pad_level = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_noise();
    t_irq();
    t_off();
    t_sens();
    t_time();
    t_over();
    wrap_up();
  end
endmodule

bind sts_standby_scan sts_scan_properties #(
  .RAW_W(RAW_W), .SAMP_UNIT_CYC(SAMP_UNIT_CYC), .CYC_UNIT_CYC(CYC_UNIT_CYC)
) u_sts_scan_properties (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .standby_mode(standby_mode), .raw_count(raw_count), .sense_enable(sense_enable),
  .sense_chan(sense_chan), .low_power_idle(low_power_idle), .scan_result(scan_result),
  .irq(irq));
`default_nettype wire
